// ==== hcfg_chk.sv ====
// port-level assertion checker for the hub configuration block
`default_nettype none

module hcfg_chk
  import hcfg_pkg::*;
#(
  parameter int unsigned DETACH_CYC = 20
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CFG_WR_EN,
  input wire logic CFG_RD_EN,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic SELF_PWR_CFG,
  input wire logic DEFAULT_CFG,
  input wire logic [1:0] FIXED_PORT_STRAP_PINS,
  input wire logic [7:0] CFG_RDATA,
  input wire logic UPSTREAM_ATTACH,
  input wire logic SELF_POWERED,
  input wire logic DS_PORT_POWER_ALLOW,
  input wire logic DS_FORCE_DISCONNECT,
  input wire logic COMPOUND_DEVICE,
  input wire logic PORT_NUMBERING_METHOD_SEL,
  input wire logic STRING_DESC_EN,
  input wire logic [3:0] FIXED_ATTACH_PORT_MASK,
  input wire logic [1:0] OVERCURRENT_DELAY_SEL
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // detach length counter; armed only once attached, so the reset rise is ignored
  logic armed;
  logic [15:0] det_cnt;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      armed <= 1'b0;
      det_cnt <= 16'h0;
    end else begin
      armed <= armed | UPSTREAM_ATTACH;
      det_cnt <= (UPSTREAM_ATTACH || !armed) ? 16'h0 : det_cnt + 16'h1;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wr(logic [7:0] a);
    CFG_WR_EN && CFG_ADDR == a;
  endsequence
  sequence s_strap;
    (DEFAULT_CFG && $stable(FIXED_PORT_STRAP_PINS))[*8];
  endsequence

  a_rd_unmapped: assert property (
    CFG_RD_EN && (CFG_ADDR < 8'h07 || CFG_ADDR > 8'h09) |=> CFG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_mask: assert property (
    CFG_RD_EN && CFG_ADDR == 8'h09 |=> CFG_RDATA[0] == 1'b0 && CFG_RDATA[7:5] == 3'h0)
    else $error("reserved mask bits read nonzero");
  a_oc_sel: assert property (
    s_wr(8'h07) |-> ##2 OVERCURRENT_DELAY_SEL == $past(CFG_WDATA[5:4], 2))
    else $error("delay select not from write");
  a_compound_cfg: assert property (
    s_wr(8'h07) ##0 !DEFAULT_CFG |-> ##2 COMPOUND_DEVICE == $past(CFG_WDATA[3], 2))
    else $error("compound not from write");
  a_byte3_fields: assert property (
    s_wr(8'h08) |-> ##2 {PORT_NUMBERING_METHOD_SEL, STRING_DESC_EN} ==
      {$past(CFG_WDATA[3], 2), $past(CFG_WDATA[0], 2)})
    else $error("byte three fields wrong");
  a_mask_cfg: assert property (
    s_wr(8'h09) ##0 !DEFAULT_CFG |-> ##2 FIXED_ATTACH_PORT_MASK == $past(CFG_WDATA[4:1], 2))
    else $error("fixed mask not from write");
  a_strap_map: assert property (
    s_strap |-> FIXED_ATTACH_PORT_MASK == {2'b00, FIXED_PORT_STRAP_PINS} &&
      COMPOUND_DEVICE == |FIXED_PORT_STRAP_PINS)
    else $error("strap mapping wrong");
  a_detach_grp: assert property (
    $fell(UPSTREAM_ATTACH) |->
      (!UPSTREAM_ATTACH && !DS_PORT_POWER_ALLOW && DS_FORCE_DISCONNECT)[*8])
    else $error("detach group broken");
  a_reattach: assert property (
    $rose(UPSTREAM_ATTACH) && det_cnt != 16'h0 |->
      det_cnt >= DETACH_CYC && DS_PORT_POWER_ALLOW && !DS_FORCE_DISCONNECT)
    else $error("reattach too early");
  a_self_pwr: assert property (
    $changed(SELF_POWERED) |-> $rose(UPSTREAM_ATTACH) || SELF_POWERED == $past(SELF_PWR_CFG))
    else $error("self powered moved alone");
endmodule

`default_nettype wire

// ==== hcfg_pkg.sv ====
// shared constants and types for the hub configuration byte block
`default_nettype none

package hcfg_pkg;

  // ==========================================================================
  // clock
  localparam real CLK_PERIOD_NS = 10.0;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_CFG_BYTE_TWO = 8'h07;
  localparam logic [7:0] ADDR_CFG_BYTE_THREE = 8'h08;
  localparam logic [7:0] ADDR_FIXED_PORT_MASK = 8'h09;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_CFG_BYTE_TWO = 8'h00;
  localparam logic [7:0] RST_CFG_BYTE_THREE = 8'h00;
  localparam logic [7:0] RST_FIXED_PORT_MASK = 8'h00;

  // ==========================================================================
  // writable bits; everything else is reserved and reads as zero
  localparam logic [7:0] WMASK_CFG_BYTE_TWO = 8'hb8;
  localparam logic [7:0] WMASK_CFG_BYTE_THREE = 8'h09;
  localparam logic [7:0] WMASK_FIXED_PORT_MASK = 8'h1e;

  // ==========================================================================
  // field positions
  localparam int DYN_SWITCH_BIT = 7;
  localparam int OC_DELAY_HI = 5;
  localparam int OC_DELAY_LO = 4;
  localparam int COMPOUND_BIT = 3;
  localparam int PORT_NUM_SEL_BIT = 3;
  localparam int STRING_EN_BIT = 0;
  localparam int PORT_MASK_HI = 4;
  localparam int PORT_MASK_LO = 1;

  // ==========================================================================
  // over-current delay selections
  localparam logic [1:0] OC_SEL_00 = 2'h0;
  localparam logic [1:0] OC_SEL_01 = 2'h1;
  localparam logic [1:0] OC_SEL_10 = 2'h2;
  localparam logic [1:0] OC_SEL_11 = 2'h3;

  // ==========================================================================
  // timing
  localparam real OC_DELAY_00_MS = 0.1;
  localparam real OC_DELAY_01_MS = 4.0;
  localparam real OC_DELAY_10_MS = 8.0;
  localparam real OC_DELAY_11_MS = 16.0;
  localparam real DETACH_HOLD_MS = 1.0;
  localparam int unsigned OC_CYCLES_00 = int'($ceil(OC_DELAY_00_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned OC_CYCLES_01 = int'($ceil(OC_DELAY_01_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned OC_CYCLES_10 = int'($ceil(OC_DELAY_10_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned OC_CYCLES_11 = int'($ceil(OC_DELAY_11_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned DETACH_CYCLES = int'($ceil(DETACH_HOLD_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CNT_W = 21;

  // ==========================================================================
  // pin synchroniser width: local supply, over-current, default cfg, two straps
  localparam int PIN_W = 5;

  // ==========================================================================
  // types
  typedef enum logic [0:0] {
    HCFG_ATTACHED,
    HCFG_DETACHED
  } hcfg_link_t;

  typedef struct packed {
    logic [PIN_W-1:0] ff1;
    logic [PIN_W-1:0] ff2;
    logic [PIN_W-1:0] ff3;
    logic [PIN_W-1:0] stable;
  } hcfg_sync_t;

  typedef struct packed {
    logic [7:0] cfg_byte_two;
    logic [7:0] cfg_byte_three;
    logic [7:0] fixed_port_mask;
    logic [7:0] rdata;
    hcfg_link_t link;
    logic [CNT_W-1:0] detach_cnt;
    logic [CNT_W-1:0] oc_cnt;
    logic local_prev;
    logic self_powered;
    logic upstream_attach;
    logic ds_power_allow;
    logic ds_disconnect;
    logic compound;
    logic port_numbering_method_sel;
    logic string_en;
    logic [3:0] fixed_attach_port_mask;
    logic [1:0] overcurrent_delay_sel;
    logic oc_fault;
  } hcfg_state_t;

endpackage

`default_nettype wire

// ==== hcfg_src.sv ====
// configuration source model: writes and reads configuration bytes
`default_nettype none

module hcfg_src
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // ==========================================================================
  // bus cycles; idle bus shows inverted values so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
  endtask

  // fixed ports go in first: the attached devices carry their own descriptors
  task automatic set_compound(input logic [3:0] ports, input logic [7:0] b2);
    wr(8'h09, {3'h0, ports, 1'b0});
    wr(8'h07, b2 | 8'h08);
  endtask
endmodule

`default_nettype wire

// ==== hcfg_sync.sv ====
// three-flop pin synchroniser with agreement filter
`default_nettype none

module hcfg_sync
  import hcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PIN_W-1:0] pins,
  output logic [PIN_W-1:0] stable
);

  // ==========================================================================
  // state
  hcfg_sync_t s;
  hcfg_sync_t next_s;
  logic [PIN_W-1:0] agree;

  // ==========================================================================
  // filter: ff1 feeds only ff2; a change counts once ff2 and ff3 agree
  always_comb begin
    next_s = s;
    next_s.ff1 = pins;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    agree = ~(s.ff2 ^ s.ff3);
    next_s.stable = (s.ff3 & agree) | (s.stable & ~agree);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign stable = s.stable;

endmodule

`default_nettype wire

// ==== hcfg_top.sv ====
// hub configuration bytes two and three, fixed-port mask, power source switching
`default_nettype none
//
// Summary of operation
// R1: bit 7 enables automatic power source switching
// R2: switching watches local supply present input
// R3: supply change drops downstream connection and power
// R4: supply change also detaches upstream port
// R5: reattach as self or bus powered
// R6: bits 5:4 select over-current delay
// R7: bit 3 reports compound device
// R8: source marks compound ports non-removable too
// R9: strap mode: any fixed port means compound
// R10: byte three bit 3 selects port numbering
// R11: byte three bit 0 enables string descriptors
// R12: mask bits 1-4 mark ports non-removable
// R13: fixed devices supply their own descriptors
// R14: default config takes mask from strap pins
// R15: switching overrides configured self-powered bit
// R16: reserved bits inert, read as zero

module hcfg_top
  import hcfg_pkg::*;
#(
  parameter int unsigned OC_CYC_00 = OC_CYCLES_00,
  parameter int unsigned OC_CYC_01 = OC_CYCLES_01,
  parameter int unsigned OC_CYC_10 = OC_CYCLES_10,
  parameter int unsigned OC_CYC_11 = OC_CYCLES_11,
  parameter int unsigned DETACH_CYC = DETACH_CYCLES
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CFG_WR_EN,
  input wire logic CFG_RD_EN,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic SELF_PWR_CFG,
  input wire logic LOCAL_SUPPLY_PRESENT,
  input wire logic OVERCURRENT_N,
  input wire logic DEFAULT_CFG,
  input wire logic [1:0] FIXED_PORT_STRAP_PINS,
  output logic [7:0] CFG_RDATA,
  output logic UPSTREAM_ATTACH,
  output logic SELF_POWERED,
  output logic DS_PORT_POWER_ALLOW,
  output logic DS_FORCE_DISCONNECT,
  output logic COMPOUND_DEVICE,
  output logic PORT_NUMBERING_METHOD_SEL,
  output logic STRING_DESC_EN,
  output logic [3:0] FIXED_ATTACH_PORT_MASK,
  output logic [1:0] OVERCURRENT_DELAY_SEL,
  output logic OVERCURRENT_FAULT
);

  // ==========================================================================
  // pin synchronisation
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_stable;
  logic local_supply_present;
  logic oc_active;
  logic default_cfg;
  logic [1:0] fixed_port_strap_pins;

  assign pins_raw = {
    FIXED_PORT_STRAP_PINS,
    DEFAULT_CFG,
    ~OVERCURRENT_N,
    LOCAL_SUPPLY_PRESENT
  };

  // straps are slow levels; they share the pin filter rather than a reset-time capture
  hcfg_sync u_sync (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .pins(pins_raw),
    .stable(pins_stable)
  );

  assign local_supply_present = pins_stable[0];
  assign oc_active = pins_stable[1];
  assign default_cfg = pins_stable[2];
  assign fixed_port_strap_pins = pins_stable[4:3];

  // ==========================================================================
  // state
  hcfg_state_t s;
  hcfg_state_t next_s;
  logic dyn_switch_en;
  logic supply_changed;
  logic [CNT_W-1:0] oc_limit;
  logic [3:0] reg_port_mask;
  logic [3:0] strap_port_mask;
  logic [3:0] eff_port_mask;

  assign dyn_switch_en = s.cfg_byte_two[DYN_SWITCH_BIT]; // [R1]
  assign supply_changed = local_supply_present != s.local_prev; // [R2]

  // ==========================================================================
  // over-current delay selection
  always_comb begin
    oc_limit = CNT_W'(OC_CYC_00);
    unique case (s.cfg_byte_two[OC_DELAY_HI:OC_DELAY_LO]) // [R6]
      OC_SEL_00: oc_limit = CNT_W'(OC_CYC_00);
      OC_SEL_01: oc_limit = CNT_W'(OC_CYC_01);
      OC_SEL_10: oc_limit = CNT_W'(OC_CYC_10);
      OC_SEL_11: oc_limit = CNT_W'(OC_CYC_11);
    endcase
  end

  // ==========================================================================
  // non-removable port selection
  always_comb begin
    reg_port_mask = s.fixed_port_mask[PORT_MASK_HI:PORT_MASK_LO]; // [R12]
    // each strap pin fixes one of the two lowest ports
    strap_port_mask = {2'h0, fixed_port_strap_pins};
    eff_port_mask = default_cfg ? strap_port_mask : reg_port_mask; // [R14]
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;

    // register writes: reserved bits are dropped so they can never steer logic
    if (CFG_WR_EN) begin
      unique case (CFG_ADDR)
        ADDR_CFG_BYTE_TWO: begin
          next_s.cfg_byte_two = CFG_WDATA & WMASK_CFG_BYTE_TWO; // [R16]
        end
        ADDR_CFG_BYTE_THREE: begin
          next_s.cfg_byte_three = CFG_WDATA & WMASK_CFG_BYTE_THREE; // [R16]
        end
        ADDR_FIXED_PORT_MASK: begin
          next_s.fixed_port_mask = CFG_WDATA & WMASK_FIXED_PORT_MASK; // [R16]
        end
        default: begin
        end
      endcase
    end

    // register reads: answer one cycle later, unmapped reads give zero
    if (CFG_RD_EN) begin
      unique case (CFG_ADDR)
        ADDR_CFG_BYTE_TWO: begin
          next_s.rdata = s.cfg_byte_two;
        end
        ADDR_CFG_BYTE_THREE: begin
          next_s.rdata = s.cfg_byte_three;
        end
        ADDR_FIXED_PORT_MASK: begin
          next_s.rdata = s.fixed_port_mask;
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // configuration outputs
    next_s.port_numbering_method_sel = s.cfg_byte_three[PORT_NUM_SEL_BIT]; // [R10]
    next_s.string_en = s.cfg_byte_three[STRING_EN_BIT]; // [R11]
    next_s.fixed_attach_port_mask = eff_port_mask; // [R12] [R14]
    next_s.overcurrent_delay_sel = s.cfg_byte_two[OC_DELAY_HI:OC_DELAY_LO]; // [R6]
    // descriptors of fixed devices come from the devices, so only the mask is exported [R13]
    if (default_cfg) begin
      next_s.compound = |strap_port_mask; // [R9]
    end else begin
      // software must mark the fixed ports itself; the bit is not cross-checked [R8]
      next_s.compound = s.cfg_byte_two[COMPOUND_BIT]; // [R7]
    end

    // over-current qualification: the fault holds while the sense stays active
    if (!oc_active) begin
      next_s.oc_cnt = '0;
      next_s.oc_fault = 1'b0;
    end else if (s.oc_cnt >= oc_limit - CNT_W'(1)) begin
      next_s.oc_fault = 1'b1; // [R6]
    end else begin
      next_s.oc_cnt = s.oc_cnt + CNT_W'(1);
    end

    // power source switching
    next_s.local_prev = local_supply_present; // [R2]
    unique case (s.link)
      HCFG_ATTACHED: begin
        next_s.upstream_attach = 1'b1;
        next_s.ds_power_allow = 1'b1;
        next_s.ds_disconnect = 1'b0;
        if (!dyn_switch_en) begin
          next_s.self_powered = SELF_PWR_CFG; // [R1]
        end else if (supply_changed) begin // [R1] [R2]
          next_s.link = HCFG_DETACHED;
          next_s.detach_cnt = '0;
          next_s.ds_power_allow = 1'b0; // [R3]
          next_s.ds_disconnect = 1'b1; // [R3]
          next_s.upstream_attach = 1'b0; // [R4]
        end
      end
      HCFG_DETACHED: begin
        next_s.ds_power_allow = 1'b0; // [R3]
        next_s.ds_disconnect = 1'b1; // [R3]
        next_s.upstream_attach = 1'b0; // [R4]
        if (supply_changed) begin
          // a bouncing supply restarts the hold so the host sees one clean detach
          next_s.detach_cnt = '0;
        end else if (s.detach_cnt >= CNT_W'(DETACH_CYC) - CNT_W'(1)) begin
          next_s.link = HCFG_ATTACHED;
          next_s.upstream_attach = 1'b1; // [R5]
          next_s.ds_power_allow = 1'b1;
          next_s.ds_disconnect = 1'b0;
          next_s.self_powered = local_supply_present; // [R5] [R15]
        end else begin
          next_s.detach_cnt = s.detach_cnt + CNT_W'(1);
        end
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '0;
      s.cfg_byte_two <= RST_CFG_BYTE_TWO;
      s.cfg_byte_three <= RST_CFG_BYTE_THREE;
      s.fixed_port_mask <= RST_FIXED_PORT_MASK;
      s.link <= HCFG_ATTACHED;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs, all straight from state flops
  assign CFG_RDATA = s.rdata;
  assign UPSTREAM_ATTACH = s.upstream_attach;
  assign SELF_POWERED = s.self_powered;
  assign DS_PORT_POWER_ALLOW = s.ds_power_allow;
  assign DS_FORCE_DISCONNECT = s.ds_disconnect;
  assign COMPOUND_DEVICE = s.compound;
  assign PORT_NUMBERING_METHOD_SEL = s.port_numbering_method_sel;
  assign STRING_DESC_EN = s.string_en;
  assign FIXED_ATTACH_PORT_MASK = s.fixed_attach_port_mask;
  assign OVERCURRENT_DELAY_SEL = s.overcurrent_delay_sel;
  assign OVERCURRENT_FAULT = s.oc_fault;

endmodule

`default_nettype wire

// ==== tb_hcfg_top.sv ====
// self-checking testbench for the hub configuration block
`default_nettype none

module tb_hcfg_top
  import hcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, resetn, self_pwr_cfg, local_supply, oc_n, default_cfg;
  logic [1:0] straps;
  logic cfg_wr_en, cfg_rd_en, up_att, self_pwr, ds_pwr, ds_disc, compound, port_sel;
  logic str_en, oc_fault;
  logic [7:0] cfg_addr, cfg_wdata, rdata, a, d;
  logic [3:0] fmask;
  logic [1:0] oc_sel;
  logic [7:0] model [7:9];
  int failures, total_checks, cycles, i, j;

  hcfg_top #(.OC_CYC_00(8), .OC_CYC_01(16), .OC_CYC_10(24), .OC_CYC_11(32),
    .DETACH_CYC(20)) dut (.REF_CLK(ref_clk), .RESETN(resetn), .CFG_WR_EN(cfg_wr_en),
    .CFG_RD_EN(cfg_rd_en), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
    .SELF_PWR_CFG(self_pwr_cfg), .LOCAL_SUPPLY_PRESENT(local_supply), .OVERCURRENT_N(oc_n),
    .DEFAULT_CFG(default_cfg), .FIXED_PORT_STRAP_PINS(straps), .CFG_RDATA(rdata),
    .UPSTREAM_ATTACH(up_att), .SELF_POWERED(self_pwr), .DS_PORT_POWER_ALLOW(ds_pwr),
    .DS_FORCE_DISCONNECT(ds_disc), .COMPOUND_DEVICE(compound),
    .PORT_NUMBERING_METHOD_SEL(port_sel), .STRING_DESC_EN(str_en),
    .FIXED_ATTACH_PORT_MASK(fmask), .OVERCURRENT_DELAY_SEL(oc_sel),
    .OVERCURRENT_FAULT(oc_fault));
  hcfg_src src (.clk(ref_clk), .rdata(rdata), .wr_en(cfg_wr_en), .rd_en(cfg_rd_en),
    .addr(cfg_addr), .wdata(cfg_wdata));

  // ==========================================================================
  // helpers
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] wmask(input logic [7:0] ad);
    case (ad)
      8'h07: wmask = WMASK_CFG_BYTE_TWO;
      8'h08: wmask = WMASK_CFG_BYTE_THREE;
      8'h09: wmask = WMASK_FIXED_PORT_MASK;
      default: wmask = 8'h00;
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // run takes about 400 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    {resetn, self_pwr_cfg, local_supply, default_cfg, straps} = 6'h00;
    oc_n = 1'b1;
    for (a = 8'h07; a <= 8'h09; a++) model[a] = 8'h00;
    void'($urandom(32'h7be9efe6));
    tick(2);
    resetn = 1'b1;
    for (a = 8'h07; a <= 8'h0a; a++) begin
      src.rd(a, d);
      check(16'(d), 16'h0000);
    end
    for (i = 0; i < 24; i++) begin
      a = 8'h06 + 8'($urandom_range(0, 4));
      d = 8'($urandom) & 8'h7f;
      self_pwr_cfg = 1'($urandom);
      src.wr(a, d);
      if (wmask(a) != 8'h00) model[a] = d & wmask(a);
      src.rd(a, d);
      check(16'(d), 16'((wmask(a) != 8'h00) ? model[a] : 8'h00));
      check(16'({oc_sel, compound, port_sel, str_en, fmask}), 16'({model[7][5:4],
        model[7][3], model[8][3], model[8][0], model[9][4:1]}));
      check(16'(self_pwr), 16'(self_pwr_cfg));
    end
    default_cfg = 1'b1;
    for (i = 0; i < 4; i++) begin
      straps = 2'(i);
      // ten edges give the strap checker at least nine stable samples per value
      tick(10);
      check(16'({compound, fmask}), 16'({|straps, 2'b00, straps}));
    end
    default_cfg = 1'b0;
    tick(8);
    src.set_compound(4'ha, 8'h00);
    tick(2);
    check(16'({compound, fmask}), 16'h001a);
    for (i = 0; i < 4; i++) begin
      src.wr(8'h07, {2'b00, 2'(i), 4'h0});
      oc_n = 1'b0;
      // four edges of pin filter come before the selected count starts
      tick(8 * (i + 1) + 3);
      check(16'(oc_fault), 16'h0000);
      tick(1);
      check(16'(oc_fault), 16'h0001);
      oc_n = 1'b1;
      tick(4);
      check(16'(oc_fault), 16'h0001);
      tick(1);
      check(16'(oc_fault), 16'h0000);
    end
    // switching off: a supply change must leave the upstream link alone
    local_supply = 1'b1;
    tick(30);
    check(16'({up_att, ds_pwr}), 16'h0003);
    src.wr(8'h07, 8'h80);
    tick(30);
    for (i = 0; i < 2; i++) begin
      local_supply = ~local_supply;
      self_pwr_cfg = ~local_supply;
      for (j = 0; j < 12 && up_att !== 1'b0; j++) tick(1);
      check(16'(j), 16'h0005);
      check(16'({up_att, ds_pwr, ds_disc}), 16'h0001);
      tick(19);
      check(16'({up_att, ds_pwr, ds_disc}), 16'h0001);
      tick(1);
      check(16'({up_att, ds_pwr, ds_disc, self_pwr}), 16'({3'b110, local_supply}));
    end
    finish_test();
  end
endmodule

bind hcfg_top hcfg_chk #(.DETACH_CYC(DETACH_CYC)) chk (.*);

`default_nettype wire
